// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import uar_pkg::*;
   localparam int K = 10;
   logic        clk, rst, awvalid, wvalid, awready, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, rx, tx, done_irq, err_irq, txd_irq, ok;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  n_done, n_err, n_tx, e_done, e_err, e_tx;
   logic [9:0]  f;
   int          n_low;
   int          miscompares, num_checks;
   uar_serial DUT (.i_clk_sys(clk), .i_reset(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_serial_rx_pin(rx), .o_serial_tx_pin(tx), .o_rx_done_irq(done_irq),
      .o_rx_error_irq(err_irq), .o_tx_done_irq(txd_irq));
   uar_remote #(.BIT_CYC(2 * K)) far (.i_clk_sys(clk), .i_tx_line(tx), .o_rx_line(rx));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      n_done <= n_done + 8'(done_irq === 1'b1);
      n_err  <= n_err + 8'(err_irq === 1'b1);
      n_tx   <= n_tx + 8'(txd_irq === 1'b1);
   end
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic hang(input int t);
      if (t >= 100) begin
         miscompares++;
         results();
      end
   endtask : hang
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      int t;
      t = 0;
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(negedge clk); while (!(awready && wready) && ++t < 100);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(negedge clk); while (bvalid !== 1'b1 && ++t < 100);
      hang(t);
      chk({bresp, 32'h0}, {RESP_OKAY, 32'h0});
      @(posedge clk);
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
      int t;
      t = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1 && ++t < 100);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1 && ++t < 100);
      hang(t);
      chk({rresp, rdata}, {er, 24'h0, d});
      @(posedge clk);
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   // even parity frame, pe flips the parity bit, st is the stop level
   task automatic rxf(input logic [7:0] d, input logic pe, input logic st);
      far.send_bits({5'h1F, st, ^d ^ pe, d, 1'b0}, 11);
      repeat (8) @(posedge clk);
   endtask : rxf
   task automatic irqs(input logic [7:0] dd, input logic [7:0] de, input logic [7:0] dt);
      e_done = e_done + dd;
      e_err  = e_err + de;
      e_tx   = e_tx + dt;
      chk({10'h0, n_done, n_err, n_tx}, {10'h0, e_done, e_err, e_tx});
   endtask : irqs
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
      {awaddr, araddr, wdata} = '0;
      {n_done, n_err, n_tx, e_done, e_err, e_tx} = '0;
      miscompares = 0;
      num_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_MODE, RST_MODE, RESP_OKAY);
      rd(OFS_RXBUF, RST_RXBUF, RESP_OKAY);
      rd(OFS_DIV, RST_DIV, RESP_OKAY);
      rd(5'h02, 8'h00, RESP_SLVERR);
      $display("test reset values done");
      wr(OFS_PRESC, 8'h00);
      wr(OFS_DIV, 8'(K));
      wr(OFS_MODE, 8'hF8);
      wr(OFS_EXT, 8'h40);
      rd(OFS_EXT, 8'hC0, RESP_OKAY);
      far.send_bits(16'h0400, 11);
      repeat (8) @(posedge clk);
      irqs(0, 0, 0);
      rd(OFS_EXT, 8'hC0, RESP_OKAY);
      far.send_bits(16'h2000, 14);
      repeat (8) @(posedge clk);
      irqs(1, 0, 0);
      rd(OFS_EXT, 8'h00, RESP_OKAY);
      rd(OFS_ERR, 8'h00, RESP_OKAY);
      rd(OFS_RXBUF, RST_RXBUF, RESP_OKAY);
      $display("test break done");
      far.glitch();
      repeat (40) @(posedge clk);
      irqs(0, 0, 0);
      rxf(8'hA5, 1'b0, 1'b1);
      irqs(1, 0, 0);
      rd(OFS_ERR, 8'h00, RESP_OKAY);
      rd(OFS_RXBUF, 8'hA5, RESP_OKAY);
      rxf(8'h3C, 1'b1, 1'b1);
      irqs(0, 1, 0);
      rd(OFS_ERR, 8'h02, RESP_OKAY);
      rd(OFS_ERR, 8'h00, RESP_OKAY);
      rd(OFS_RXBUF, 8'h3C, RESP_OKAY);
      rxf(8'h5A, 1'b0, 1'b0);
      irqs(0, 1, 0);
      rd(OFS_ERR, 8'h04, RESP_OKAY);
      rd(OFS_RXBUF, 8'h5A, RESP_OKAY);
      rxf(8'h11, 1'b0, 1'b1);
      rxf(8'h22, 1'b0, 1'b1);
      irqs(1, 1, 0);
      rd(OFS_ERR, 8'h01, RESP_OKAY);
      rd(OFS_RXBUF, 8'h11, RESP_OKAY);
      wr(OFS_MODE, 8'hF9);
      rxf(8'h77, 1'b1, 1'b1);
      irqs(1, 0, 0);
      rd(OFS_ERR, 8'h02, RESP_OKAY);
      rd(OFS_RXBUF, 8'h77, RESP_OKAY);
      $display("test receive errors done");
      fork
         wr(OFS_TXBUF, 8'hC7);
         far.get_frame(f, ok);
      join
      chk({33'h0, ok}, {33'h0, 1'b1});
      chk({24'h0, f}, {24'h0, 2'b11, 8'hC7});
      repeat (8) @(posedge clk);
      irqs(0, 0, 1);
      $display("test transmit done");
      // break field: 00H, even parity, divisor stretched by 1.3
      wr(OFS_DIV, 8'(K * 13 / 10));
      fork
         wr(OFS_TXBUF, 8'h00);
         far.low_width(n_low);
      join
      chk(34'(n_low), 34'(13 * 2 * K));
      repeat (40) @(posedge clk);
      irqs(0, 0, 1);
      $display("test break send done");
      // base tick every second clock; phase of the tick gives one cycle of slack
      wr(OFS_DIV, 8'(K));
      wr(OFS_PRESC, 8'h01);
      fork
         wr(OFS_TXBUF, 8'h00);
         far.low_width(n_low);
      join
      chk(34'((n_low + 1) / 2), 34'(10 * 2 * K));
      repeat (100) @(posedge clk);
      irqs(0, 0, 1);
      wr(OFS_PRESC, 8'h00);
      wr(OFS_MODE, 8'h00);
      wr(OFS_TXBUF, 8'h55);
      repeat (40) @(posedge clk);
      rd(OFS_TXSTAT, 8'h00, RESP_OKAY);
      irqs(0, 0, 0);
      $display("test prescaler and power done");
      wr(OFS_MODE, 8'hF0);
      rxf(8'h5A, 1'b0, 1'b1);
      irqs(0, 1, 0);
      rd(OFS_ERR, 8'h02, RESP_OKAY);
      rd(OFS_RXBUF, 8'h5A, RESP_OKAY);
      wr(OFS_MODE, 8'hE8);
      rxf(8'h5A, 1'b1, 1'b1);
      irqs(1, 0, 0);
      rd(OFS_ERR, 8'h00, RESP_OKAY);
      rd(OFS_RXBUF, 8'h5A, RESP_OKAY);
      $display("test parity modes done");
      results();
   end
endmodule : tb_top
`default_nettype wire

// ==== dv/uar_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
module uar_remote #(
   parameter int BIT_CYC = 16
) (
   input  wire logic i_clk_sys,
   input  wire logic i_tx_line,
   output logic      o_rx_line
);
   initial o_rx_line = 1'b1;
   // lsb first, line back to idle high after the last bit
   task automatic send_bits(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         o_rx_line <= bits[i];
         repeat (BIT_CYC) @(posedge i_clk_sys);
      end
      o_rx_line <= 1'b1;
   endtask : send_bits
   task automatic glitch();
      o_rx_line <= 1'b0;
      @(posedge i_clk_sys);
      o_rx_line <= 1'b1;
   endtask : glitch
   // samples mid-bit: data, parity, stop
   task automatic get_frame(output logic [9:0] f, output logic ok);
      int t;
      t = 0;
      while (i_tx_line !== 1'b0 && t < 4000) begin
         @(negedge i_clk_sys);
         t++;
      end
      ok = (t < 4000);
      repeat (BIT_CYC + BIT_CYC / 2) @(negedge i_clk_sys);
      for (int i = 0; i < 10; i++) begin
         f[i] = i_tx_line;
         repeat (BIT_CYC) @(negedge i_clk_sys);
      end
   endtask : get_frame
   // cycles the tx line stays low from its next falling edge; 0 on timeout
   task automatic low_width(output int n);
      int t;
      t = 0;
      n = 0;
      while (i_tx_line !== 1'b0 && t < 4000) begin
         @(negedge i_clk_sys);
         t++;
      end
      while (i_tx_line === 1'b0 && n < 4000) begin
         @(negedge i_clk_sys);
         n++;
      end
   endtask : low_width
endmodule : uar_remote
`default_nettype wire

// ==== dv/uar_serial_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module uar_serial_checker (
   input wire logic        i_clk_sys,
   input wire logic        i_reset,
   input wire logic        i_awvalid,
   input wire logic        i_wvalid,
   input wire logic        o_awready,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic        i_arvalid,
   input wire logic        o_rvalid,
   input wire logic        i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic        o_serial_tx_pin,
   input wire logic        o_rx_done_irq,
   input wire logic        o_rx_error_irq,
   input wire logic        o_tx_done_irq
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);
   wr_resp_a: assert property (i_awvalid && i_wvalid && !o_bvalid |=> o_bvalid)
      else $error("write not answered");
   wr_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped");
   rd_resp_a: assert property (i_arvalid && !o_rvalid |=> o_rvalid)
      else $error("read not answered");
   rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");
   rd_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
      else $error("read upper bits set");
   aw_refuse_a: assert property (o_awready |-> !o_bvalid)
      else $error("write taken while response pending");
   rx_pulse_a: assert property (o_rx_done_irq |=> !o_rx_done_irq)
      else $error("done pulse too long");
   tx_pulse_a: assert property (o_tx_done_irq |=> !o_tx_done_irq)
      else $error("tx pulse too long");
   irq_excl_a: assert property (o_rx_error_irq |-> !o_rx_done_irq ##1 !o_rx_error_irq)
      else $error("error and done together");
   tx_idle_a: assert property ($fell(i_reset) |-> o_serial_tx_pin)
      else $error("tx pin not idle");
endmodule : uar_serial_checker
bind uar_serial uar_serial_checker chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_awvalid(i_awvalid),
   .i_wvalid(i_wvalid), .o_awready(o_awready), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .i_arvalid(i_arvalid), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
   .o_serial_tx_pin(o_serial_tx_pin), .o_rx_done_irq(o_rx_done_irq),
   .o_rx_error_irq(o_rx_error_irq), .o_tx_done_irq(o_tx_done_irq));
`default_nettype wire

// ==== logic/uar_pkg.sv ====
`default_nettype none
package uar_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_MODE   = 5'h00;
   localparam logic [4:0] OFS_ERR    = 5'h04;
   localparam logic [4:0] OFS_RXBUF  = 5'h08;
   localparam logic [4:0] OFS_TXBUF  = 5'h0C;
   localparam logic [4:0] OFS_PRESC  = 5'h10;
   localparam logic [4:0] OFS_DIV    = 5'h14;
   localparam logic [4:0] OFS_EXT    = 5'h18;
   localparam logic [4:0] OFS_TXSTAT = 5'h1C;
   localparam logic [7:0] RST_MODE   = 8'h00;
   localparam logic [7:0] RST_RXBUF  = 8'hFF;
   localparam logic [7:0] RST_DIV    = 8'hFF;
   localparam logic [3:0] RST_PRESC  = 4'h0;
   localparam int         EXT_TRIG   = 6;
   localparam int         EXT_FLAG   = 7;
   localparam logic [3:0] BRK_MIN    = 4'hB;
   localparam logic [3:0] DATA_LAST  = 4'h8;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // parity modes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   typedef struct packed {
      logic       power_on_bit;
      logic       tx_enable_bit;
      logic       rx_enable_bit;
      logic [1:0] parity;
      logic       two_stop;
      logic       spare;
      logic       irq_merge_sel;
   } uar_mode_type;

   typedef struct packed {
      logic framing_err_flag;
      logic parity_err_flag;
      logic overrun_flag;
   } uar_err_type;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } uar_rx_state_type;
endpackage : uar_pkg
`default_nettype wire

// ==== logic/uar_serial.sv ====
`timescale 1ns/1ps
`default_nettype none
module uar_serial #(
   parameter int PRESC_W = 11
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic [4:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [4:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   input  wire logic        i_serial_rx_pin,
   output logic             o_serial_tx_pin,
   output logic             o_rx_done_irq,
   output logic             o_rx_error_irq,
   output logic             o_tx_done_irq
);
   import uar_pkg::*;

   uar_mode_type     mode_reg;
   uar_err_type      err_reg;
   logic [7:0]       rx_buffer_reg;
   logic             rx_full_reg;
   logic [7:0]       tx_buffer_reg;
   logic             tx_full_reg;
   logic [3:0]       presc_sel_reg;
   logic [7:0]       divisor_reg;
   logic             brk_trig_reg;
   logic             brk_flag_reg;
   logic             bvalid_reg;
   logic [1:0]       bresp_reg;
   logic             rvalid_reg;
   logic [31:0]      rdata_reg;
   logic [1:0]       rresp_reg;
   logic             tx_busy;

   // bus decode
   wire wr_go = i_awvalid & i_wvalid & ~bvalid_reg;
   wire rd_go = i_arvalid & ~rvalid_reg;
   wire wr_b0 = wr_go & i_wstrb[0];
   wire wr_mode = wr_b0 & (i_awaddr == OFS_MODE);
   wire wr_txb  = wr_b0 & (i_awaddr == OFS_TXBUF);
   wire wr_psc  = wr_b0 & (i_awaddr == OFS_PRESC);
   wire wr_div  = wr_b0 & (i_awaddr == OFS_DIV);
   wire wr_ext  = wr_b0 & (i_awaddr == OFS_EXT);
   wire wr_hit  = (i_awaddr == OFS_MODE) | (i_awaddr == OFS_TXBUF) | (i_awaddr == OFS_PRESC) |
                  (i_awaddr == OFS_DIV) | (i_awaddr == OFS_EXT) | (i_awaddr == OFS_ERR) |
                  (i_awaddr == OFS_RXBUF) | (i_awaddr == OFS_TXSTAT);
   wire rd_err  = rd_go & (i_araddr == OFS_ERR);
   wire rd_rxb  = rd_go & (i_araddr == OFS_RXBUF);
   logic [7:0] rd_val;
   logic       rd_hit;
   assign o_awready = wr_go;
   assign o_wready  = wr_go;
   assign o_arready = rd_go;
   assign o_bvalid  = bvalid_reg;
   assign o_bresp   = bresp_reg;
   assign o_rvalid  = rvalid_reg;
   assign o_rdata   = rdata_reg;
   assign o_rresp   = rresp_reg;

   always_comb begin
      rd_hit = 1'b1;
      case (i_araddr)
         OFS_MODE:   rd_val = mode_reg;
         OFS_ERR:    rd_val = {5'h00, err_reg};
         OFS_RXBUF:  rd_val = rx_buffer_reg;
         OFS_TXBUF:  rd_val = tx_buffer_reg;
         OFS_PRESC:  rd_val = {4'h0, presc_sel_reg};
         OFS_DIV:    rd_val = divisor_reg;
         OFS_EXT:    rd_val = {brk_flag_reg, brk_trig_reg, 6'h00};
         OFS_TXSTAT: rd_val = {6'h00, tx_full_reg, tx_busy};
         default: begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end else begin
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (rd_go) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rd_val};
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // base clock as an enable tick; a gated clock would split the domain
   logic [PRESC_W-1:0] presc_cnt_reg;
   wire [PRESC_W-1:0] presc_mask = PRESC_W'((1 << presc_sel_reg) - 1);
   wire base_tick = mode_reg.power_on_bit & ((presc_cnt_reg & presc_mask) == presc_mask);
   wire [7:0] k_last = divisor_reg - 8'h01;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset | ~mode_reg.power_on_bit) begin
         presc_cnt_reg <= '0;
      end else begin
         presc_cnt_reg <= presc_cnt_reg + PRESC_W'(1);
      end
   end

   // pin sync then two-sample match filter
   logic sync1_reg;
   logic sync2_reg;
   logic samp_reg;
   logic rxd_reg;
   logic rxd_old_reg;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sync1_reg   <= 1'b1;
         sync2_reg   <= 1'b1;
         samp_reg    <= 1'b1;
         rxd_reg     <= 1'b1;
         rxd_old_reg <= 1'b1;
      end else begin
         sync1_reg <= i_serial_rx_pin;
         sync2_reg <= sync1_reg;
         if (base_tick) begin
            samp_reg    <= sync2_reg;
            rxd_old_reg <= rxd_reg;
            if (samp_reg == sync2_reg) begin
               rxd_reg <= samp_reg;
            end
         end
      end
   end

   // receiver
   uar_rx_state_type rx_state_reg;
   logic [7:0] rx_cnt_reg;
   logic       rx_half_reg;
   logic [3:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic       rx_perr_reg;
   logic [3:0] brk_cnt_reg;
   wire rx_on   = mode_reg.power_on_bit & mode_reg.rx_enable_bit;
   wire rx_wrap = base_tick & (rx_cnt_reg == k_last);
   wire rx_samp = rx_wrap & rx_half_reg;
   wire rx_fall = base_tick & rxd_old_reg & ~rxd_reg;
   wire rx_par_bad = (mode_reg.parity == PAR_ODD)  ? ~(^{rx_shift_reg, rxd_reg}) :
                     (mode_reg.parity == PAR_EVEN) ?  (^{rx_shift_reg, rxd_reg}) : 1'b0;
   wire stop_ev = rx_samp & (rx_state_reg == RX_STOP);
   wire brk_end = stop_ev & brk_trig_reg & rxd_reg;
   wire brk_ok  = brk_end & (brk_cnt_reg >= BRK_MIN);
   wire nrm_end = stop_ev & ~brk_trig_reg;
   uar_err_type new_err;
   assign new_err.framing_err_flag = ~rxd_reg;
   assign new_err.parity_err_flag  = rx_perr_reg;
   assign new_err.overrun_flag     = rx_full_reg;
   wire any_err = nrm_end & (|new_err);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset | ~rx_on) begin
         rx_state_reg <= RX_IDLE;
         rx_cnt_reg   <= 8'h00;
         rx_half_reg  <= 1'b1;
         rx_bit_reg   <= 4'h0;
         rx_shift_reg <= 8'h00;
         rx_perr_reg  <= 1'b0;
         brk_cnt_reg  <= 4'h0;
      end else begin
         if (rx_state_reg != RX_IDLE && rx_wrap) begin
            rx_cnt_reg  <= 8'h00;
            rx_half_reg <= ~rx_half_reg;
         end else if (rx_state_reg != RX_IDLE && base_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
         end
         if (rx_samp && !rxd_reg && brk_cnt_reg != 4'hF) begin
            brk_cnt_reg <= brk_cnt_reg + 4'h1;
         end
         case (rx_state_reg)
            RX_IDLE: begin
               rx_cnt_reg  <= 8'h00;
               rx_half_reg <= 1'b1;
               brk_cnt_reg <= 4'h0;
               if (rx_fall) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               rx_perr_reg <= 1'b0;
               rx_bit_reg  <= 4'h1;
               if (rx_samp) begin
                  rx_state_reg <= rxd_reg ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_samp) begin
                  rx_shift_reg <= {rxd_reg, rx_shift_reg[7:1]};
                  rx_bit_reg   <= rx_bit_reg + 4'h1;
                  if (rx_bit_reg == DATA_LAST) begin
                     rx_state_reg <= (mode_reg.parity == PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
            end
            RX_PAR: begin
               if (rx_samp) begin
                  rx_perr_reg  <= rx_par_bad;
                  rx_state_reg <= RX_STOP;
               end
            end
            RX_STOP: begin
               // break keeps sampling while the line stays low
               if (nrm_end || brk_end) begin
                  rx_state_reg <= RX_IDLE;
               end
            end
            default: begin
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // status, buffers, break control, interrupts
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         mode_reg      <= RST_MODE;
         err_reg       <= '0;
         rx_buffer_reg <= RST_RXBUF;
         rx_full_reg   <= 1'b0;
         presc_sel_reg <= RST_PRESC;
         divisor_reg   <= RST_DIV;
         brk_trig_reg  <= 1'b0;
         brk_flag_reg  <= 1'b0;
         o_rx_done_irq  <= 1'b0;
         o_rx_error_irq <= 1'b0;
      end else begin
         if (wr_mode) mode_reg <= i_wdata[7:0];
         if (wr_psc) presc_sel_reg <= i_wdata[3:0];
         if (wr_div) divisor_reg <= i_wdata[7:0];
         if (rd_err) err_reg <= '0;
         // capture in the read cycle wins, but the flags just read are dropped
         if (any_err) err_reg <= rd_err ? new_err : err_reg | new_err;
         if (rd_rxb) rx_full_reg <= 1'b0;
         if (nrm_end && !rx_full_reg) begin
            rx_buffer_reg <= rx_shift_reg;
            rx_full_reg   <= 1'b1;
         end
         if (wr_ext && i_wdata[EXT_TRIG]) begin
            brk_trig_reg <= 1'b1;
            brk_flag_reg <= 1'b1;
         end
         if (brk_ok) begin
            brk_trig_reg <= 1'b0;
            brk_flag_reg <= 1'b0;
         end
         o_rx_done_irq  <= brk_ok | (nrm_end & (~any_err | mode_reg.irq_merge_sel));
         o_rx_error_irq <= any_err & ~mode_reg.irq_merge_sel;
      end
   end

   // transmitter
   logic [7:0]  tx_cnt_reg;
   logic        tx_half_reg;
   logic [11:0] tx_frame_reg;
   logic [3:0]  tx_left_reg;
   wire tx_on   = mode_reg.power_on_bit & mode_reg.tx_enable_bit;
   wire tx_bit  = base_tick & (tx_cnt_reg == k_last) & tx_half_reg;
   wire tx_end  = tx_busy & tx_bit & (tx_left_reg == 4'h1);
   wire tx_load = (~tx_busy & tx_full_reg) | (tx_end & tx_full_reg);
   wire tx_par  = (mode_reg.parity == PAR_ODD)  ? ~(^tx_buffer_reg) :
                  (mode_reg.parity == PAR_EVEN) ?  (^tx_buffer_reg) : 1'b0;
   wire has_par = (mode_reg.parity != PAR_NONE);
   assign tx_busy = (tx_left_reg != 4'h0);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset | ~tx_on) begin
         tx_cnt_reg      <= 8'h00;
         tx_half_reg     <= 1'b0;
         tx_frame_reg    <= 12'hFFF;
         tx_left_reg     <= 4'h0;
         tx_full_reg     <= 1'b0;
         o_serial_tx_pin <= 1'b1;
         o_tx_done_irq   <= 1'b0;
      end else begin
         o_tx_done_irq <= tx_end;
         if (wr_txb) tx_full_reg <= 1'b1;
         if (tx_load) begin
            tx_cnt_reg   <= 8'h00;
            tx_half_reg  <= 1'b0;
            tx_full_reg  <= 1'b0;
            tx_frame_reg <= {2'h3, has_par ? tx_par : 1'b1, tx_buffer_reg, 1'b0};
            tx_left_reg  <= 4'hA + {3'h0, has_par} + {3'h0, mode_reg.two_stop};
         end else begin
            if (base_tick && tx_cnt_reg == k_last) begin
               tx_cnt_reg  <= 8'h00;
               tx_half_reg <= ~tx_half_reg;
            end else if (base_tick) begin
               tx_cnt_reg <= tx_cnt_reg + 8'h01;
            end
            if (tx_bit && tx_busy) begin
               tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
               tx_left_reg  <= tx_left_reg - 4'h1;
            end
         end
         o_serial_tx_pin <= tx_busy ? tx_frame_reg[0] : 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tx_buffer_reg <= 8'h00;
      end else if (wr_txb) begin
         tx_buffer_reg <= i_wdata[7:0];
      end
   end
endmodule : uar_serial
`default_nettype wire
